/* hdl/link_sync_consts.svh */
// Purpose: constants for the link start-up and reference capture block
// Assumes: byte-wide registers at their printed offsets
// Notes: timing counts are in sampling-clock cycles
`ifndef LINK_SYNC_CONSTS_SVH
`define LINK_SYNC_CONSTS_SVH
`define ADDR_CAPTURE_CONTROL 12'h030
`define ADDR_CAPTURE_STATUS 12'h031
`define ADDR_DELAY_SELECT 12'h032
`define ADDR_LINK_CONFIG 12'h033
`define ADDR_LINK_STATUS 12'h034
`define ADDR_SYNC_SELECT 12'h202
`define BIT_INPUT_ENABLE 7
`define BIT_PROCESSING_ENABLE 6
`define BIT_EDGE_SEEN_CLEAR 5
`define BIT_ERROR_CLEAR 4
`define BIT_EDGE_SEEN_FLAG 7
`define BIT_CAPTURE_ERROR_FLAG 6
`define BIT_SYNC_INPUT_SELECT 6
`define RST_CAPTURE_CONTROL 8'h00
`define RST_DELAY_SELECT 8'h00
`define RST_LINK_CONFIG 8'h00
`define RST_SYNC_SELECT 8'h00
`define LMFC_PERIOD_DEFAULT 8'h20
`define ILA_MULTIFRAMES 3'h4
`define K28_5_SYMBOL 8'hbc
`define ILA_START_SYMBOL 8'h1c
`define ILA_END_SYMBOL 8'h7c
`define DELAY_TAPS 16
`endif

/* hdl/link_sync_pkg.sv */
// Purpose: types for the link start-up and reference capture block
// Assumes: nothing beyond the constants header
// Notes: states are one-hot
package link_sync_pkg;
  typedef enum logic [3:0] {
    ST_COMMA = 4'h1,
    ST_WAIT_LMFC = 4'h2,
    ST_ALIGN = 4'h4,
    ST_DATA = 4'h8
  } link_state_t;
  typedef enum logic [2:0] {
    DEC_BYPASS = 3'h0,
    DEC_4 = 3'h1,
    DEC_8 = 3'h2,
    DEC_10 = 3'h3,
    DEC_16 = 3'h4,
    DEC_20 = 3'h5,
    DEC_32 = 3'h6
  } decim_mode_t;
endpackage : link_sync_pkg

/* hdl/link_sync_top.sv */
// Purpose: link start-up handshake, multiframe alignment and reference capture
// Assumes: register port with read data one cycle after the read strobe
// Notes: lane payload beyond control symbols comes in on sample ports
// Overview of operation
// - send comma symbols while request active
// - after release, commas until chosen multiframe boundary
// - alignment sequence begins after that boundary
// - reference passes a 4-bit programmable delay
// - sticky flag on captured rising reference edge
// - sticky flag on marginal reference capture
// - control bit clears the edge-seen flag
// - control bit clears the capture-error flag
// - reference input enabled only by control bit
// - reference processing only while enabled
// - oscillator phase reset during alignment when decimating
// - bypass outputs raw 12-bit samples full rate
// - decimating outputs complex samples at reduced rate
// - sync request is active low
// - select bit picks single or differential sync
// - captured edge aligns local multiframe counter
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "link_sync_consts.svh"
module link_sync_top
  import link_sync_pkg::*;
(
  input wire logic clk_in, // sampling clock
  input wire logic sys_rst_in, // synchronous active-high reset
  input wire logic [11:0] reg_addr_in, // register address
  input wire logic [7:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [7:0] reg_rdata_out, // read data, cycle after strobe
  input wire logic sync_se_n_in, // single-ended sync request, low active
  input wire logic sync_diff_n_in, // differential sync request, low active
  input wire logic sysref_in, // reference pulse
  input wire logic [11:0] raw_sample_in, // converter sample
  input wire logic [14:0] i_sample_in, // decimated in-phase sample
  input wire logic [14:0] q_sample_in, // decimated quadrature sample
  output logic [7:0] lane_symbol_out, // symbol to encoder
  output logic lane_is_k_out, // symbol is a control character
  output logic nco_phase_reset_out, // oscillator accumulator reset
  output logic [11:0] raw_sample_out, // bypass sample
  output logic [14:0] i_sample_out, // decimated in-phase
  output logic [14:0] q_sample_out, // decimated quadrature
  output logic sample_valid_out, // sample strobe
  output logic lmfc_boundary_out // local multiframe boundary pulse
);
  typedef struct packed {
    link_state_t st;
    logic [7:0] ctrl;
    logic [7:0] delay;
    logic [7:0] cfg;
    logic [7:0] sync_sel;
    logic edge_seen_flag;
    logic capture_error_flag;
    logic ref_prev;
    logic [7:0] lmfc_cnt;
    logic [2:0] skip_cnt;
    logic [2:0] ila_mf;
    logic [7:0] ila_oct;
    logic [4:0] dec_cnt;
    logic [7:0] rdata;
    logic [7:0] sym;
    logic is_k;
    logic nco_rst;
    logic [11:0] raw;
    logic [14:0] i_s;
    logic [14:0] q_s;
    logic valid;
    logic lmfc_pulse;
  } top_state_t;
  top_state_t s_q, s_d;
  logic ref_gated;
  logic ref_delayed;
  logic marginal;
  logic sync_n;
  logic ref_rise;
  logic lmfc_wrap;
  logic [4:0] dec_factor;
  decim_mode_t mode;

  assign ref_gated = sysref_in & s_q.ctrl[`BIT_INPUT_ENABLE];
  sysref_delay_line u_delay (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ref_in(ref_gated),
    .delay_in(s_q.delay[3:0]),
    .ref_out(ref_delayed),
    .marginal_out(marginal)
  );

  assign sync_n = s_q.sync_sel[`BIT_SYNC_INPUT_SELECT] ? sync_diff_n_in : sync_se_n_in;
  assign ref_rise = ref_delayed & ~s_q.ref_prev;
  assign lmfc_wrap = s_q.lmfc_cnt == `LMFC_PERIOD_DEFAULT - 8'h01;
  assign mode = decim_mode_t'(s_q.cfg[2:0]);

  always_comb begin
    unique case (mode)
      DEC_4: dec_factor = 5'd3;
      DEC_8: dec_factor = 5'd7;
      DEC_10: dec_factor = 5'd9;
      DEC_16: dec_factor = 5'd15;
      DEC_20: dec_factor = 5'd19;
      DEC_32: dec_factor = 5'd31;
      default: dec_factor = 5'd0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ref_prev = ref_delayed;
    s_d.lmfc_pulse = 1'b0;
    s_d.nco_rst = 1'b0;
    s_d.valid = 1'b0;
    s_d.rdata = 8'h00;
    // registers
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `ADDR_CAPTURE_CONTROL: s_d.ctrl = reg_wdata_in;
        `ADDR_DELAY_SELECT: s_d.delay = {4'h0, reg_wdata_in[3:0]};
        `ADDR_LINK_CONFIG: s_d.cfg = {2'h0, reg_wdata_in[5:0]};
        `ADDR_SYNC_SELECT: s_d.sync_sel = reg_wdata_in & 8'h40;
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `ADDR_CAPTURE_CONTROL: s_d.rdata = s_q.ctrl;
        `ADDR_CAPTURE_STATUS: s_d.rdata = {s_q.edge_seen_flag, s_q.capture_error_flag, 6'h00};
        `ADDR_DELAY_SELECT: s_d.rdata = s_q.delay;
        `ADDR_LINK_CONFIG: s_d.rdata = s_q.cfg;
        `ADDR_LINK_STATUS: s_d.rdata = {4'h0, s_q.st};
        `ADDR_SYNC_SELECT: s_d.rdata = s_q.sync_sel;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // sticky capture flags: the clear is held while its bit stays one,
    // but an edge in the same cycle still sets the flag
    if (s_q.ctrl[`BIT_EDGE_SEEN_CLEAR]) begin
      s_d.edge_seen_flag = 1'b0;
    end
    if (s_q.ctrl[`BIT_ERROR_CLEAR]) begin
      s_d.capture_error_flag = 1'b0;
    end
    if (ref_rise) begin
      s_d.edge_seen_flag = 1'b1;
      if (marginal) begin
        s_d.capture_error_flag = 1'b1;
      end
    end
    // local multiframe counter, realigned by a processed reference edge
    if (ref_rise && s_q.ctrl[`BIT_PROCESSING_ENABLE]) begin
      s_d.lmfc_cnt = 8'h00;
      s_d.lmfc_pulse = 1'b1;
    end else if (lmfc_wrap) begin
      s_d.lmfc_cnt = 8'h00;
      s_d.lmfc_pulse = 1'b1;
    end else begin
      s_d.lmfc_cnt = s_q.lmfc_cnt + 8'h01;
    end
    // link start-up sequence
    unique case (s_q.st)
      ST_COMMA: begin
        s_d.sym = `K28_5_SYMBOL;
        s_d.is_k = 1'b1;
        if (sync_n) begin
          s_d.st = ST_WAIT_LMFC;
          s_d.skip_cnt = s_q.cfg[5:3];
        end
      end
      ST_WAIT_LMFC: begin
        s_d.sym = `K28_5_SYMBOL;
        s_d.is_k = 1'b1;
        if (s_d.lmfc_pulse) begin
          if (s_q.skip_cnt == 3'h0) begin
            s_d.st = ST_ALIGN;
            s_d.ila_mf = 3'h0;
            s_d.ila_oct = 8'h00;
          end else begin
            s_d.skip_cnt = s_q.skip_cnt - 3'h1;
          end
        end
      end
      ST_ALIGN: begin
        s_d.nco_rst = mode != DEC_BYPASS;
        s_d.is_k = s_q.ila_oct == 8'h00 || lmfc_wrap;
        s_d.sym = s_q.ila_oct == 8'h00 ? `ILA_START_SYMBOL :
                  lmfc_wrap ? `ILA_END_SYMBOL : s_q.ila_oct;
        s_d.ila_oct = lmfc_wrap ? 8'h00 : s_q.ila_oct + 8'h01;
        if (lmfc_wrap) begin
          if (s_q.ila_mf == `ILA_MULTIFRAMES - 3'h1) begin
            s_d.st = ST_DATA;
            s_d.dec_cnt = 5'h00;
          end else begin
            s_d.ila_mf = s_q.ila_mf + 3'h1;
          end
        end
      end
      ST_DATA: begin
        s_d.is_k = 1'b0;
        s_d.sym = 8'h00;
        if (mode == DEC_BYPASS) begin
          s_d.raw = raw_sample_in;
          s_d.valid = 1'b1;
        end else if (s_q.dec_cnt >= dec_factor) begin
          s_d.i_s = i_sample_in;
          s_d.q_s = q_sample_in;
          s_d.valid = 1'b1;
          s_d.dec_cnt = 5'h00;
        end else begin
          s_d.dec_cnt = s_q.dec_cnt + 5'h01;
        end
      end
      default: s_d.st = ST_COMMA;
    endcase
    // a new request from any later state drops back to commas
    if (!sync_n) begin
      s_d.st = ST_COMMA;
    end
    if (sys_rst_in) begin
      s_d = '0;
      s_d.st = ST_COMMA;
      s_d.ctrl = `RST_CAPTURE_CONTROL;
      s_d.delay = `RST_DELAY_SELECT;
      s_d.cfg = `RST_LINK_CONFIG;
      s_d.sync_sel = `RST_SYNC_SELECT;
      s_d.sym = `K28_5_SYMBOL;
      s_d.is_k = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end

  assign reg_rdata_out = s_q.rdata;
  assign lane_symbol_out = s_q.sym;
  assign lane_is_k_out = s_q.is_k;
  assign nco_phase_reset_out = s_q.nco_rst;
  assign raw_sample_out = s_q.raw;
  assign i_sample_out = s_q.i_s;
  assign q_sample_out = s_q.q_s;
  assign sample_valid_out = s_q.valid;
  assign lmfc_boundary_out = s_q.lmfc_pulse;
endmodule : link_sync_top

/* hdl/sysref_delay_line.sv */
// Purpose: programmable delay of the reference input in whole clock taps
// Assumes: reference arrives synchronous to the sampling clock
// Notes: a pulse one tap wide at the chosen tap is reported as a marginal capture
`timescale 1ns/10ps
`include "link_sync_consts.svh"
module sysref_delay_line
  import link_sync_pkg::*;
(
  input wire logic clk_in, // sampling clock
  input wire logic sys_rst_in, // synchronous reset
  input wire logic ref_in, // gated reference input
  input wire logic [3:0] delay_in, // tap select
  output logic ref_out, // delayed reference
  output logic marginal_out // neighbouring taps disagree
);
  typedef struct packed {
    logic [`DELAY_TAPS-1:0] taps;
  } dl_state_t;
  dl_state_t s_q, s_d;
  logic [`DELAY_TAPS:0] ext;
  always_comb begin
    s_d = s_q;
    s_d.taps = {s_q.taps[`DELAY_TAPS-2:0], ref_in};
    if (sys_rst_in) begin
      s_d.taps = '0;
    end
  end
  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end
  assign ext = {s_q.taps, ref_in};
  assign ref_out = s_q.taps[delay_in];
  // the older neighbour always differs at a rising edge, so only the newer one is judged:
  // a pulse gone again one tap later means its edge sat too close to the clock
  assign marginal_out = ext[{1'b0, delay_in} + 5'h1] != ext[{1'b0, delay_in}];
endmodule : sysref_delay_line

/* tb/link_sync_top_asserts.sv */
// Purpose: port-level checks of link start-up and register port
// Assumes: bench drives both sync inputs low only when it means a request
// Notes: bound to every link_sync_top instance
`timescale 1ns/10ps
module link_sync_top_asserts (
  input wire logic clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic [11:0] reg_addr_in, // address
  input wire logic reg_rd_in, // read strobe
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic sync_se_n_in, // sync, single-ended
  input wire logic sync_diff_n_in, // sync, differential
  input wire logic [7:0] lane_symbol_out, // symbol
  input wire logic lane_is_k_out, // control flag
  input wire logic nco_phase_reset_out, // oscillator reset
  input wire logic sample_valid_out, // sample strobe
  input wire logic lmfc_boundary_out // boundary pulse
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  reset_state_a: assert property ($fell(sys_rst_in) |-> lane_symbol_out == 8'hbc && lane_is_k_out
    && !sample_valid_out && !nco_phase_reset_out) else $error("bad state after reset");
  sync_comma_a: assert property ((!sync_se_n_in && !sync_diff_n_in)[*2] |=>
    lane_symbol_out == 8'hbc && lane_is_k_out) else $error("no comma under request");
  comma_no_data_a: assert property ((lane_symbol_out == 8'hbc && lane_is_k_out)[*2] |->
    !sample_valid_out) else $error("samples during commas");
  ila_start_a: assert property ($rose(nco_phase_reset_out) |-> ##[0:2]
    (lane_symbol_out == 8'h1c && lane_is_k_out)) else $error("alignment start missing");
  lmfc_pulse_a: assert property (lmfc_boundary_out |=> !lmfc_boundary_out)
    else $error("boundary pulse too long");
  lmfc_period_a: assert property (lmfc_boundary_out |-> ##[1:64] lmfc_boundary_out)
    else $error("boundary pulse missing");
  rd_idle_zero_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in == 12'h0ff |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule : link_sync_top_asserts
bind link_sync_top link_sync_top_asserts chk_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .sync_se_n_in(sync_se_n_in), .sync_diff_n_in(sync_diff_n_in),
  .lane_symbol_out(lane_symbol_out), .lane_is_k_out(lane_is_k_out),
  .nco_phase_reset_out(nco_phase_reset_out), .sample_valid_out(sample_valid_out),
  .lmfc_boundary_out(lmfc_boundary_out));

/* tb/link_sync_top_tb.sv */
// Purpose: self-checking bench for link start-up and reference capture
// Assumes: register reads answer one cycle after the strobe
// Notes: sample inputs are held constant so outputs are predictable
`timescale 1ns/10ps
module link_sync_top_tb;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000, raw;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, sym;
  logic diff_n = 1'b1, resync = 1'b0, ref_en = 1'b0, se_n, sysref, is_k, nco, sv;
  logic ref_short = 1'b0, lmfc;
  logic [14:0] i_o, q_o;
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  sync_receiver_model rx (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .resync_in(resync),
    .ref_en_in(ref_en), .ref_short_in(ref_short), .symbol_in(sym), .is_k_in(is_k),
    .sync_n_out(se_n), .sysref_out(sysref));
  link_sync_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sync_se_n_in(se_n), .sync_diff_n_in(diff_n),
    .sysref_in(sysref), .raw_sample_in(12'h5a5), .i_sample_in(15'h1234),
    .q_sample_in(15'h0bcd), .lane_symbol_out(sym), .lane_is_k_out(is_k),
    .nco_phase_reset_out(nco), .raw_sample_out(raw), .i_sample_out(i_o),
    .q_sample_out(q_o), .sample_valid_out(sv), .lmfc_boundary_out(lmfc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // every access takes two cycles so no strobe is driven twice in one step
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
    if (!w) chk(32'(reg_rdata_out & m), 32'(d & m));
    @(posedge clk_in);
  endtask : acc
  task automatic link_run(input logic [2:0] code, input int fac);
    int n1c;
    int seen;
    int t;
    acc(1'b1, 12'h033, {5'h00, code}, 8'h00);
    resync <= 1'b1;
    @(posedge clk_in);
    resync <= 1'b0;
    repeat (4) @(posedge clk_in);
    n1c = 0;
    seen = 0;
    for (t = 0; t < 600 && sv !== 1'b1; t++) begin
      @(posedge clk_in);
      #1;
      n1c += int'(sym === 8'h1c && is_k === 1'b1);
      seen |= int'(nco === 1'b1);
    end
    chk(n1c, 4);
    chk(seen, int'(code != 3'h0));
    if (code == 3'h0) chk(32'(raw), 32'h5a5);
    else chk(32'({i_o, q_o}), {2'b00, 15'h1234, 15'h0bcd});
    for (t = 1; t < 40; t++) begin
      @(posedge clk_in);
      #1;
      if (sv === 1'b1) break;
    end
    chk(t, fac);
    @(posedge clk_in);
  endtask : link_run
  task automatic regs_test;
    acc(1'b0, 12'h030, 8'h00, 8'hff);
    acc(1'b0, 12'h202, 8'h00, 8'hff);
    acc(1'b0, 12'h0ff, 8'h00, 8'hff);
    acc(1'b1, 12'h031, 8'hff, 8'h00);
    acc(1'b0, 12'h031, 8'h00, 8'hff);
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 12'h032, 8'(i), 8'h00);
      acc(1'b0, 12'h032, 8'(i), 8'h0f);
    end
    acc(1'b1, 12'h032, 8'h08, 8'h00);
  endtask : regs_test
  task automatic decim_test;
    int fac [7] = '{1, 4, 8, 10, 16, 20, 32};
    for (int m = 0; m < 7; m++) link_run(3'(m), fac[m]);
  endtask : decim_test
  task automatic select_test;
    acc(1'b1, 12'h202, 8'h40, 8'h00);
    acc(1'b0, 12'h202, 8'h40, 8'hff);
    diff_n <= 1'b0;
    resync <= 1'b1;
    @(posedge clk_in);
    resync <= 1'b0;
    repeat (100) @(posedge clk_in);
    acc(1'b0, 12'h034, 8'h01, 8'h0f);
    diff_n <= 1'b1;
    acc(1'b1, 12'h202, 8'h00, 8'h00);
  endtask : select_test
  // with delay tap 8 the edge is seen 9 cycles after the pin rises and the
  // realigned boundary pulse is registered one cycle later
  task automatic lmfc_chk(input logic exp);
    @(posedge sysref);
    repeat (10) @(posedge clk_in);
    #1;
    chk(32'(lmfc), 32'(exp));
    @(posedge clk_in);
  endtask : lmfc_chk
  task automatic sysref_test;
    ref_en <= 1'b1;
    repeat (80) @(posedge clk_in);
    acc(1'b0, 12'h031, 8'h00, 8'hc0);
    acc(1'b1, 12'h030, 8'h80, 8'h00);
    repeat (80) @(posedge clk_in);
    // enabling the input mid-pulse may leave a short first pulse, so start clean
    acc(1'b1, 12'h030, 8'h90, 8'h00);
    acc(1'b1, 12'h030, 8'h80, 8'h00);
    lmfc_chk(1'b0);
    acc(1'b0, 12'h031, 8'h80, 8'hc0);
    acc(1'b1, 12'h030, 8'hc0, 8'h00);
    lmfc_chk(1'b1);
    ref_short <= 1'b1;
    repeat (80) @(posedge clk_in);
    acc(1'b0, 12'h031, 8'hc0, 8'hc0);
    ref_short <= 1'b0;
    ref_en <= 1'b0;
    repeat (40) @(posedge clk_in);
    acc(1'b0, 12'h031, 8'hc0, 8'hc0);
    acc(1'b1, 12'h030, 8'hf0, 8'h00);
    acc(1'b0, 12'h031, 8'h00, 8'hc0);
    acc(1'b1, 12'h030, 8'hc0, 8'h00);
    acc(1'b0, 12'h031, 8'h00, 8'hc0);
  endtask : sysref_test
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    regs_test();
    decim_test();
    select_test();
    sysref_test();
    end_of_test();
  end
endmodule : link_sync_top_tb

/* tb/sync_receiver_model.sv */
// Purpose: far-end receiver and reference source
// Assumes: one lane, reference period equal to one multiframe
// Notes: a new request is raised only when the bench asks for it;
// a one-cycle reference pulse can be asked for to provoke a marginal capture
`timescale 1ns/10ps
module sync_receiver_model (
  input wire logic clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic resync_in, // bench asks for a new request
  input wire logic ref_en_in, // run the reference
  input wire logic ref_short_in, // one-cycle reference pulses
  input wire logic [7:0] symbol_in, // lane symbol
  input wire logic is_k_in, // control flag
  output logic sync_n_out, // request, low active
  output logic sysref_out // reference pulse
);
  logic [2:0] k_cnt_q;
  logic [4:0] ref_cnt_q;
  always_ff @(posedge clk_in) begin
    ref_cnt_q <= sys_rst_in ? 5'h00 : ref_cnt_q + 5'h01;
    sysref_out <= !sys_rst_in && ref_en_in && ref_cnt_q < (ref_short_in ? 5'h01 : 5'h04);
    if (sys_rst_in || resync_in) begin
      sync_n_out <= 1'b0;
      k_cnt_q <= 3'h0;
    end else if (!sync_n_out) begin
      // lock is lost on any symbol that is not a comma
      k_cnt_q <= (is_k_in && symbol_in == 8'hbc) ? k_cnt_q + 3'h1 : 3'h0;
      if (k_cnt_q == 3'h4) sync_n_out <= 1'b1;
    end
  end
endmodule : sync_receiver_model
